// File: t2cc_pkg.sv
package t2cc_pkg;

  // data-space offsets
  localparam logic [7:0] T2CC_ADDR_FLAGS       = 8'h37;
  localparam logic [7:0] T2CC_ADDR_ENABLES     = 8'h70;
  localparam logic [7:0] T2CC_ADDR_CTRL_B      = 8'hB1;
  localparam logic [7:0] T2CC_ADDR_COUNT       = 8'hB2;
  localparam logic [7:0] T2CC_ADDR_CMP_FIRST   = 8'hB3;
  localparam logic [7:0] T2CC_ADDR_CMP_SECOND  = 8'hB4;
  // i/o space is data space minus this, and only spans below the limit
  localparam logic [7:0] T2CC_IO_OFFSET        = 8'h20;
  localparam logic [7:0] T2CC_IO_LIMIT         = 8'h40;
  localparam logic [7:0] T2CC_NO_ADDR          = 8'h00;

  // timer_control_b fields
  localparam int T2CC_BIT_FORCE_FIRST  = 7;
  localparam int T2CC_BIT_FORCE_SECOND = 6;
  localparam int T2CC_BIT_WAVE_HIGH    = 3;
  localparam int T2CC_CS_MSB           = 2;
  localparam int T2CC_CS_LSB           = 0;

  // flag / enable bit positions
  localparam int T2CC_BIT_OVF        = 0;
  localparam int T2CC_BIT_MATCH_A    = 1;
  localparam int T2CC_BIT_MATCH_B    = 2;
  localparam int T2CC_IRQ_BITS       = 3;

  localparam logic [7:0] T2CC_RESET_BYTE = 8'h00;
  localparam logic [7:0] T2CC_COUNT_MAX  = 8'hFF;
  localparam logic [7:0] T2CC_COUNT_BOT  = 8'h00;
  localparam logic [7:0] T2CC_COUNT_STEP = 8'h01;

  // clock select codes and prescaler masks
  localparam int          T2CC_PRESC_W   = 10;
  localparam logic [2:0]  T2CC_CS_STOP   = 3'h0;
  localparam logic [2:0]  T2CC_CS_DIV1   = 3'h1;
  localparam logic [2:0]  T2CC_CS_DIV8   = 3'h2;
  localparam logic [2:0]  T2CC_CS_DIV32  = 3'h3;
  localparam logic [2:0]  T2CC_CS_DIV64  = 3'h4;
  localparam logic [2:0]  T2CC_CS_DIV128 = 3'h5;
  localparam logic [2:0]  T2CC_CS_DIV256 = 3'h6;
  localparam logic [9:0]  T2CC_MASK_8    = 10'h007;
  localparam logic [9:0]  T2CC_MASK_32   = 10'h01F;
  localparam logic [9:0]  T2CC_MASK_64   = 10'h03F;
  localparam logic [9:0]  T2CC_MASK_128  = 10'h07F;
  localparam logic [9:0]  T2CC_MASK_256  = 10'h0FF;
  localparam logic [9:0]  T2CC_MASK_1024 = 10'h3FF;
  localparam logic [9:0]  T2CC_PRESC_ONE = 10'h001;
  localparam logic [9:0]  T2CC_PRESC_RST = 10'h000;

  // output action codes
  localparam logic [1:0] T2CC_ACT_OFF    = 2'h0;
  localparam logic [1:0] T2CC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] T2CC_ACT_CLEAR  = 2'h2;
  localparam logic [1:0] T2CC_ACT_SET    = 2'h3;

  typedef enum logic [2:0] {
    T2CC_MODE_NORMAL,
    T2CC_MODE_PC_FULL,
    T2CC_MODE_CTC,
    T2CC_MODE_FAST_FULL,
    T2CC_MODE_PC_TOPA,
    T2CC_MODE_FAST_TOPA
  } t2cc_mode_t;

  localparam logic [2:0] T2CC_WGM_PC_FULL   = 3'h1;
  localparam logic [2:0] T2CC_WGM_CTC       = 3'h2;
  localparam logic [2:0] T2CC_WGM_FAST_FULL = 3'h3;
  localparam logic [2:0] T2CC_WGM_PC_TOPA   = 3'h5;
  localparam logic [2:0] T2CC_WGM_FAST_TOPA = 3'h7;

endpackage

// File: t2cc_channel.sv
`timescale 1ns/10ps
module t2cc_channel
  import t2cc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire logic              block,
  input  wire logic [7:0]        count,
  input  wire logic [7:0]        compare,
  input  wire t2cc_pkg::t2cc_mode_t mode,
  input  wire logic              down,
  input  wire logic              bottom,
  input  wire logic [1:0]        action,
  input  wire logic              toggle_ok,
  input  wire logic              force_hit,
  output logic                   match,
  output logic                   wave_out
);
  import t2cc_pkg::*;

  typedef struct packed {
    logic wave;
  } t2cc_chan_t;

  t2cc_chan_t s_ff;
  t2cc_chan_t nxt_s;
  logic       pwm_fast;
  logic       pwm_pc;

  assign pwm_fast = (mode == T2CC_MODE_FAST_FULL) || (mode == T2CC_MODE_FAST_TOPA);
  assign pwm_pc   = (mode == T2CC_MODE_PC_FULL) || (mode == T2CC_MODE_PC_TOPA);
  // a counter write masks the very next tick's match on both channels
  assign match    = tick && !block && (count == compare);
  assign wave_out = s_ff.wave;

  always_comb begin
    nxt_s = s_ff;
    if (force_hit) begin
      // force acts on the pin only; the caller gates it to non-pwm modes
      unique case (action)
        T2CC_ACT_TOGGLE: nxt_s.wave = !s_ff.wave;
        T2CC_ACT_CLEAR:  nxt_s.wave = 1'b0;
        T2CC_ACT_SET:    nxt_s.wave = 1'b1;
        default:         nxt_s.wave = s_ff.wave;
      endcase
    end else if (match) begin
      if (pwm_fast) begin
        unique case (action)
          T2CC_ACT_TOGGLE: nxt_s.wave = toggle_ok ? !s_ff.wave : s_ff.wave;
          T2CC_ACT_CLEAR:  nxt_s.wave = 1'b0;
          T2CC_ACT_SET:    nxt_s.wave = 1'b1;
          default:         nxt_s.wave = s_ff.wave;
        endcase
      end else if (pwm_pc) begin
        unique case (action)
          T2CC_ACT_TOGGLE: nxt_s.wave = toggle_ok ? !s_ff.wave : s_ff.wave;
          T2CC_ACT_CLEAR:  nxt_s.wave = down;
          T2CC_ACT_SET:    nxt_s.wave = !down;
          default:         nxt_s.wave = s_ff.wave;
        endcase
      end else begin
        unique case (action)
          T2CC_ACT_TOGGLE: nxt_s.wave = !s_ff.wave;
          T2CC_ACT_CLEAR:  nxt_s.wave = 1'b0;
          T2CC_ACT_SET:    nxt_s.wave = 1'b1;
          default:         nxt_s.wave = s_ff.wave;
        endcase
      end
    end
    // applied last so a compare equal to top still lands at bottom
    if (bottom && pwm_fast) begin
      if (action == T2CC_ACT_CLEAR) begin
        nxt_s.wave = 1'b1;
      end else if (action == T2CC_ACT_SET) begin
        nxt_s.wave = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// File: t2cc_timer.sv
`timescale 1ns/10ps
// What this block does
// - force first acts only in non-pwm modes
// - force first applies its output action now
// - force first sets no flag, no clear
// - force first bit always reads zero
// - force second acts only in non-pwm modes
// - force second applies its output action now
// - force second sets no flag, no clear
// - force second bit always reads zero
// - clock select: stop, /1, /8 ... /1024
// - counter is directly readable and writable
// - counter write blocks next tick's matches
// - compare first drives flag and wave output
// - compare second drives flag and wave output
// - second match irq needs enable, global, flag
// - first match irq needs enable, global, flag
// - overflow irq needs enable, global, flag
// - flags at data 0x37 and io 0x17
// - flags clear by vector or one-write
// - phase-correct overflow on reversal at zero
// - mode bits pick sequence, top, waveform
module t2cc_timer
  import t2cc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] core_addr,
  input  wire logic       core_io_space,
  input  wire logic       core_wr,
  input  wire logic       core_rd,
  input  wire logic [7:0] core_wdata,
  output logic [7:0]      core_rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       vec_ack_overflow,
  input  wire logic       vec_ack_match_first,
  input  wire logic       vec_ack_match_second,
  input  wire logic [1:0] wave_mode_low,
  input  wire logic [1:0] output_action_first,
  input  wire logic [1:0] output_action_second,
  output logic            irq_overflow,
  output logic            irq_match_first,
  output logic            irq_match_second,
  output logic            wave_out_first,
  output logic            wave_out_second
);
  import t2cc_pkg::*;

  typedef struct packed {
    logic [7:0]                    count;
    logic [7:0]                    cmp_first;
    logic [7:0]                    cmp_second;
    logic [T2CC_IRQ_BITS-1:0]      enables;
    logic [T2CC_IRQ_BITS-1:0]      flags;
    logic                          wave_high;
    logic [2:0]                    clk_sel;
    logic [T2CC_PRESC_W-1:0]       prescale;
    logic                          down;
    logic                          block;
    logic [7:0]                    rdata;
    logic [T2CC_IRQ_BITS-1:0]      irq;
  } t2cc_state_t;

  t2cc_state_t              s_ff;
  t2cc_state_t              nxt_s;
  t2cc_mode_t               mode;
  logic [7:0]               eff_addr;
  logic                     wr_flags;
  logic                     wr_enables;
  logic                     wr_ctrl;
  logic                     wr_count;
  logic                     wr_cmp_first;
  logic                     wr_cmp_second;
  logic                     non_pwm;
  logic                     tick;
  logic [T2CC_PRESC_W-1:0]  presc_mask;
  logic [7:0]               top;
  logic                     at_top;
  logic                     bottom;
  logic                     ovf_event;
  logic                     force_first;
  logic                     force_second;
  logic                     match_first;
  logic                     match_second;
  logic [T2CC_IRQ_BITS-1:0] hw_set;
  logic [T2CC_IRQ_BITS-1:0] hw_clr;

  // mode decode; reserved codes fall back to normal counting
  always_comb begin
    unique case ({s_ff.wave_high, wave_mode_low})
      T2CC_WGM_PC_FULL:   mode = T2CC_MODE_PC_FULL;
      T2CC_WGM_CTC:       mode = T2CC_MODE_CTC;
      T2CC_WGM_FAST_FULL: mode = T2CC_MODE_FAST_FULL;
      T2CC_WGM_PC_TOPA:   mode = T2CC_MODE_PC_TOPA;
      T2CC_WGM_FAST_TOPA: mode = T2CC_MODE_FAST_TOPA;
      default:            mode = T2CC_MODE_NORMAL;
    endcase
  end

  assign non_pwm = (mode == T2CC_MODE_NORMAL) || (mode == T2CC_MODE_CTC);

  always_comb begin
    unique case (mode)
      T2CC_MODE_CTC, T2CC_MODE_PC_TOPA, T2CC_MODE_FAST_TOPA: top = s_ff.cmp_first;
      default:                                             top = T2CC_COUNT_MAX;
    endcase
  end

  // both i/o and data-space decode onto one internal address
  always_comb begin
    if (!core_io_space) begin
      eff_addr = core_addr;
    end else if (core_addr < T2CC_IO_LIMIT) begin
      eff_addr = core_addr + T2CC_IO_OFFSET;
    end else begin
      eff_addr = T2CC_NO_ADDR;
    end
  end

  assign wr_flags      = core_wr && (eff_addr == T2CC_ADDR_FLAGS);
  assign wr_enables    = core_wr && (eff_addr == T2CC_ADDR_ENABLES);
  assign wr_ctrl       = core_wr && (eff_addr == T2CC_ADDR_CTRL_B);
  assign wr_count      = core_wr && (eff_addr == T2CC_ADDR_COUNT);
  assign wr_cmp_first  = core_wr && (eff_addr == T2CC_ADDR_CMP_FIRST);
  assign wr_cmp_second = core_wr && (eff_addr == T2CC_ADDR_CMP_SECOND);

  // force strobes use the mode in force at the moment of the write
  assign force_first  = wr_ctrl && core_wdata[T2CC_BIT_FORCE_FIRST] && non_pwm;
  assign force_second = wr_ctrl && core_wdata[T2CC_BIT_FORCE_SECOND] && non_pwm;

  // prescaler: one free counter, the select picks which carry ticks
  always_comb begin
    unique case (s_ff.clk_sel)
      T2CC_CS_DIV8:   presc_mask = T2CC_MASK_8;
      T2CC_CS_DIV32:  presc_mask = T2CC_MASK_32;
      T2CC_CS_DIV64:  presc_mask = T2CC_MASK_64;
      T2CC_CS_DIV128: presc_mask = T2CC_MASK_128;
      T2CC_CS_DIV256: presc_mask = T2CC_MASK_256;
      default:        presc_mask = T2CC_MASK_1024;
    endcase
  end

  always_comb begin
    if (s_ff.clk_sel == T2CC_CS_STOP) begin
      tick = 1'b0;
    end else if (s_ff.clk_sel == T2CC_CS_DIV1) begin
      tick = 1'b1;
    end else begin
      tick = (s_ff.prescale & presc_mask) == presc_mask;
    end
  end

  assign at_top = s_ff.count == top;
  assign bottom = tick && at_top;

  // overflow source depends on the counting sequence
  always_comb begin
    unique case (mode)
      T2CC_MODE_PC_FULL, T2CC_MODE_PC_TOPA: begin
        ovf_event = tick && s_ff.down && (s_ff.count == T2CC_COUNT_BOT);
      end
      T2CC_MODE_FAST_FULL, T2CC_MODE_FAST_TOPA: begin
        ovf_event = tick && at_top;
      end
      default: begin
        ovf_event = tick && (s_ff.count == T2CC_COUNT_MAX);
      end
    endcase
  end

  t2cc_channel u_chan_first (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick      (tick),
    .block     (s_ff.block),
    .count     (s_ff.count),
    .compare   (s_ff.cmp_first),
    .mode      (mode),
    .down      (s_ff.down),
    .bottom    (bottom),
    .action    (output_action_first),
    .toggle_ok (s_ff.wave_high),
    .force_hit (force_first),
    .match     (match_first),
    .wave_out  (wave_out_first)
  );

  // toggle in pwm modes is not offered on the second channel
  t2cc_channel u_chan_second (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick      (tick),
    .block     (s_ff.block),
    .count     (s_ff.count),
    .compare   (s_ff.cmp_second),
    .mode      (mode),
    .down      (s_ff.down),
    .bottom    (bottom),
    .action    (output_action_second),
    .toggle_ok (1'b0),
    .force_hit (force_second),
    .match     (match_second),
    .wave_out  (wave_out_second)
  );

  // forces never reach these sets, only real matches and overflows do
  always_comb begin
    hw_set                   = '0;
    hw_set[T2CC_BIT_OVF]     = ovf_event;
    hw_set[T2CC_BIT_MATCH_A] = match_first;
    hw_set[T2CC_BIT_MATCH_B] = match_second;
    hw_clr                   = '0;
    hw_clr[T2CC_BIT_OVF]     = vec_ack_overflow;
    hw_clr[T2CC_BIT_MATCH_A] = vec_ack_match_first;
    hw_clr[T2CC_BIT_MATCH_B] = vec_ack_match_second;
    if (wr_flags) begin
      hw_clr = hw_clr | core_wdata[T2CC_IRQ_BITS-1:0];
    end
  end

  always_comb begin
    nxt_s = s_ff;

    if (s_ff.clk_sel == T2CC_CS_STOP) begin
      nxt_s.prescale = T2CC_PRESC_RST;
    end else begin
      nxt_s.prescale = s_ff.prescale + T2CC_PRESC_ONE;
    end

    // counting sequence; force strobes have no path in here
    if (tick) begin
      nxt_s.block = 1'b0;
      unique case (mode)
        T2CC_MODE_PC_FULL, T2CC_MODE_PC_TOPA: begin
          if (!s_ff.down) begin
            if (at_top && (s_ff.count != T2CC_COUNT_BOT)) begin
              nxt_s.down  = 1'b1;
              nxt_s.count = s_ff.count - T2CC_COUNT_STEP;
            end else if (!at_top) begin
              nxt_s.count = s_ff.count + T2CC_COUNT_STEP;
            end
          end else if (s_ff.count == T2CC_COUNT_BOT) begin
            nxt_s.down  = 1'b0;
            nxt_s.count = s_ff.count + T2CC_COUNT_STEP;
          end else begin
            nxt_s.count = s_ff.count - T2CC_COUNT_STEP;
          end
        end
        default: begin
          nxt_s.down = 1'b0;
          if (at_top) begin
            nxt_s.count = T2CC_COUNT_BOT;
          end else begin
            nxt_s.count = s_ff.count + T2CC_COUNT_STEP;
          end
        end
      endcase
    end

    // a software write takes the counter over the running count
    if (wr_count) begin
      nxt_s.count = core_wdata;
      nxt_s.block = 1'b1;
    end
    if (wr_cmp_first) begin
      nxt_s.cmp_first = core_wdata;
    end
    if (wr_cmp_second) begin
      nxt_s.cmp_second = core_wdata;
    end
    if (wr_enables) begin
      nxt_s.enables = core_wdata[T2CC_IRQ_BITS-1:0];
    end
    if (wr_ctrl) begin
      nxt_s.wave_high = core_wdata[T2CC_BIT_WAVE_HIGH];
      nxt_s.clk_sel   = core_wdata[T2CC_CS_MSB:T2CC_CS_LSB];
    end

    // an event in the clearing cycle survives
    nxt_s.flags = (s_ff.flags & ~hw_clr) | hw_set;

    // requests update in the same cycle as the flags, through a flop
    nxt_s.irq = nxt_s.flags & nxt_s.enables & {T2CC_IRQ_BITS{global_irq_enable}};

    if (core_rd) begin
      nxt_s.rdata = T2CC_RESET_BYTE;
      unique case (eff_addr)
        T2CC_ADDR_FLAGS:      nxt_s.rdata[T2CC_IRQ_BITS-1:0] = s_ff.flags;
        T2CC_ADDR_ENABLES:    nxt_s.rdata[T2CC_IRQ_BITS-1:0] = s_ff.enables;
        T2CC_ADDR_CTRL_B: begin
          // force bits hold no state and read as zero
          nxt_s.rdata[T2CC_BIT_WAVE_HIGH]         = s_ff.wave_high;
          nxt_s.rdata[T2CC_CS_MSB:T2CC_CS_LSB]    = s_ff.clk_sel;
        end
        T2CC_ADDR_COUNT:      nxt_s.rdata = s_ff.count;
        T2CC_ADDR_CMP_FIRST:  nxt_s.rdata = s_ff.cmp_first;
        T2CC_ADDR_CMP_SECOND: nxt_s.rdata = s_ff.cmp_second;
        default:              nxt_s.rdata = T2CC_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign core_rdata       = s_ff.rdata;
  assign irq_overflow     = s_ff.irq[T2CC_BIT_OVF];
  assign irq_match_first  = s_ff.irq[T2CC_BIT_MATCH_A];
  assign irq_match_second = s_ff.irq[T2CC_BIT_MATCH_B];

endmodule

// File: t2cc_timer_monitor.sv
`timescale 1ns/10ps
module t2cc_timer_monitor
  import t2cc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] core_addr,
  input wire logic       core_io_space,
  input wire logic       core_wr,
  input wire logic       core_rd,
  input wire logic [7:0] core_wdata,
  input wire logic [7:0] core_rdata,
  input wire logic       global_irq_enable,
  input wire logic       irq_overflow,
  input wire logic       irq_match_first,
  input wire logic       irq_match_second
);
  logic rd_data;
  logic rd_io;
  logic wr_enables;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  assign rd_data    = core_rd && !core_io_space;
  assign rd_io      = core_rd && core_io_space;
  assign wr_enables = core_wr && !core_io_space && core_addr == T2CC_ADDR_ENABLES;

  force_read_zero_a: assert property (rd_data && core_addr == T2CC_ADDR_CTRL_B
    |=> core_rdata[7:6] == 2'h0) else $error("force bits read back nonzero");
  io_unmapped_zero_a: assert property (
    rd_io && core_addr != (T2CC_ADDR_FLAGS - T2CC_IO_OFFSET) |=> core_rdata == T2CC_RESET_BYTE)
    else $error("unmapped io read not zero");
  flag_spare_bits_a: assert property (
    (rd_data && core_addr == T2CC_ADDR_FLAGS) || (rd_io && core_addr == 8'h17)
    |=> core_rdata[7:3] == 5'h00) else $error("spare flag bits nonzero");
  rdata_hold_a: assert property (!core_rd |=> $stable(core_rdata))
    else $error("read data moved without a read");
  // requests are registered, so they follow the gate one cycle late
  irq_second_gate_a: assert property (irq_match_second |-> $past(global_irq_enable))
    else $error("second match request without global enable");
  irq_first_mask_a: assert property (wr_enables && !core_wdata[1]
    |-> ##2 !irq_match_first) else $error("first match request after mask");
  irq_ovf_gate_a: assert property (!global_irq_enable |=> !irq_overflow)
    else $error("overflow request without global enable");
  irq_ovf_mask_a: assert property (wr_enables && !core_wdata[0]
    |=> ##1 !irq_overflow) else $error("overflow request after mask");

  cover property ($rose(irq_match_first));
  cover property (rd_io && core_addr == 8'h17);
  cover property (wr_enables ##2 !irq_overflow);
endmodule

// File: t2cc_core_model.sv
`timescale 1ns/10ps
module t2cc_core_model
  import t2cc_pkg::*;
(
  input  wire logic       mclk,
  output logic [7:0]      core_addr,
  output logic            core_io_space,
  output logic            core_wr,
  output logic            core_rd,
  output logic [7:0]      core_wdata,
  output logic            global_irq_enable,
  output logic [2:0]      vec_ack,
  output logic [1:0]      wave_mode_low
);
  logic pwm_force_ok;

  initial begin
    core_addr = T2CC_NO_ADDR;
    core_io_space = 1'h0;
    core_wr = 1'h0;
    core_rd = 1'h0;
    core_wdata = 8'h00;
    global_irq_enable = 1'h0;
    vec_ack = 3'h0;
    wave_mode_low = 2'h0;
    pwm_force_ok = 1'h0;
  end

  task automatic access(input logic w, input logic [7:0] a, input logic io, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (w && !pwm_force_ok && a == T2CC_ADDR_CTRL_B && wave_mode_low[0]) begin
      v[7:6] = 2'h0;
    end
    @(posedge mclk);
    core_wr <= w;
    core_rd <= !w;
    core_addr <= a;
    core_io_space <= io;
    core_wdata <= v;
    @(posedge mclk);
    core_wr <= 1'h0;
    core_rd <= 1'h0;
    // released lines flip so a stale value can never look valid
    core_addr <= ~a;
    core_wdata <= ~v;
  endtask

  task automatic set_irq(input logic g, input logic [2:0] ack);
    @(posedge mclk);
    global_irq_enable <= g;
    vec_ack <= ack;
    @(posedge mclk);
    vec_ack <= 3'h0;
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge mclk);
    wave_mode_low <= m;
  endtask
endmodule

// File: t2cc_timer_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("FAIL %0t got %0h want %0h", $time, (got), (exp)); \
    end \
  end
module t2cc_timer_tb;
  import t2cc_pkg::*;
  logic       mclk = 1'h0;
  logic       rst_n = 1'h0;
  logic [7:0] core_addr, core_wdata, core_rdata, v, e_v;
  logic       core_io_space, core_wr, core_rd, global_irq_enable;
  logic [2:0] vec_ack;
  logic [1:0] wave_mode_low;
  logic [1:0] act_a = 2'h0;
  logic [1:0] act_b = 2'h0;
  logic       irq_overflow, irq_match_first, irq_match_second;
  logic       wave_out_first, wave_out_second;
  logic       rd_seen = 1'h0;
  logic [7:0] exp_q[$];
  int         mismatches = 0;
  int         n_compared = 0;
  int         seed = 32'h4fb7;
  logic [7:0] regs_all[6] = '{8'h37, 8'h70, 8'hB1, 8'hB2, 8'hB3, 8'hB4};
  logic [7:0] addr_tab[4] = '{8'h70, 8'hB2, 8'hB3, 8'hB4};
  logic [1:0] act_tab[4] = '{T2CC_ACT_SET, T2CC_ACT_CLEAR, T2CC_ACT_TOGGLE, T2CC_ACT_TOGGLE};
  logic       wave_tab[4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  int         div_tab[7] = '{1, 8, 32, 64, 128, 256, 1024};

  always #2.5 mclk = ~mclk;

  t2cc_core_model i_t2cc_core_model (.mclk(mclk), .core_addr(core_addr),
    .core_io_space(core_io_space), .core_wr(core_wr), .core_rd(core_rd),
    .core_wdata(core_wdata), .global_irq_enable(global_irq_enable),
    .vec_ack(vec_ack), .wave_mode_low(wave_mode_low));

  t2cc_timer i_t2cc_timer (.mclk(mclk), .rst_n(rst_n), .core_addr(core_addr),
    .core_io_space(core_io_space), .core_wr(core_wr), .core_rd(core_rd),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .global_irq_enable(global_irq_enable),
    .vec_ack_overflow(vec_ack[0]), .vec_ack_match_first(vec_ack[1]),
    .vec_ack_match_second(vec_ack[2]), .wave_mode_low(wave_mode_low),
    .output_action_first(act_a), .output_action_second(act_b),
    .irq_overflow(irq_overflow), .irq_match_first(irq_match_first),
    .irq_match_second(irq_match_second), .wave_out_first(wave_out_first),
    .wave_out_second(wave_out_second));

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'h0);
    i_t2cc_core_model.access(1'h1, a, io, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic io = 1'h0);
    exp_q.push_back(e);
    i_t2cc_core_model.access(1'h0, a, io, 8'h00);
  endtask

  // counter runs from the first write edge to the stop write edge, l cycles
  task automatic run(input logic [2:0] cs, input int l);
    wr(T2CC_ADDR_CTRL_B, {5'h00, cs});
    repeat (l - 2) @(posedge mclk);
    wr(T2CC_ADDR_CTRL_B, 8'h00);
  endtask

  always @(posedge mclk) rd_seen <= core_rd;
  always @(negedge mclk) begin
    if (rd_seen && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      `CHK(core_rdata, e_v)
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    foreach (regs_all[i]) rd(regs_all[i], 8'h00);
    rd(8'h17, 8'h00, 1'h1);
    $display("test reset_values done");
    for (int n = 0; n < 4; n++) begin
      foreach (addr_tab[i]) begin
        v = 8'($random(seed));
        wr(addr_tab[i], v);
        rd(addr_tab[i], (i == 0) ? (v & 8'h07) : v);
      end
    end
    wr(T2CC_ADDR_CTRL_B, 8'hF8);
    rd(T2CC_ADDR_CTRL_B, 8'h08);
    wr(T2CC_ADDR_CTRL_B, 8'h00);
    rd(8'h38, 8'h00);
    rd(8'h50, 8'h00, 1'h1);
    $display("test register_access done");
    i_t2cc_core_model.set_mode(2'h2);
    wr(T2CC_ADDR_COUNT, 8'h55);
    for (int ch = 0; ch < 2; ch++) begin
      foreach (act_tab[i]) begin
        @(posedge mclk);
        if (ch == 0) act_a <= act_tab[i];
        else act_b <= act_tab[i];
        wr(T2CC_ADDR_CTRL_B, (ch == 0) ? 8'h80 : 8'h40);
        #1;
        `CHK((ch == 0) ? wave_out_first : wave_out_second, wave_tab[i])
      end
    end
    rd(T2CC_ADDR_FLAGS, 8'h00);
    rd(T2CC_ADDR_COUNT, 8'h55);
    @(posedge mclk);
    act_a <= T2CC_ACT_SET;
    act_b <= T2CC_ACT_SET;
    i_t2cc_core_model.set_mode(2'h1);
    i_t2cc_core_model.pwm_force_ok = 1'h1;
    wr(T2CC_ADDR_CTRL_B, 8'hC0);
    #1;
    `CHK({wave_out_first, wave_out_second}, 2'h0)
    i_t2cc_core_model.pwm_force_ok = 1'h0;
    i_t2cc_core_model.set_mode(2'h0);
    $display("test force_strobes done");
    // half a period of margin after the second tick; the prescaler restarts from zero
    foreach (div_tab[i]) begin
      wr(T2CC_ADDR_COUNT, 8'h00);
      run(3'(i + 1), 2 * div_tab[i] + div_tab[i] / 2);
      rd(T2CC_ADDR_COUNT, 8'h02);
    end
    repeat (10) @(posedge mclk);
    rd(T2CC_ADDR_COUNT, 8'h02);
    $display("test clock_select done");
    wr(T2CC_ADDR_FLAGS, 8'h07);
    @(posedge mclk);
    act_a <= T2CC_ACT_CLEAR;
    act_b <= T2CC_ACT_CLEAR;
    wr(T2CC_ADDR_CTRL_B, 8'hC0);
    act_a <= T2CC_ACT_TOGGLE;
    wr(T2CC_ADDR_COUNT, 8'h10);
    wr(T2CC_ADDR_CMP_FIRST, 8'h12);
    wr(T2CC_ADDR_CMP_SECOND, 8'h13);
    wr(T2CC_ADDR_ENABLES, 8'h07);
    i_t2cc_core_model.set_irq(1'h1, 3'h0);
    run(3'h1, 10);
    rd(T2CC_ADDR_FLAGS, 8'h06);
    rd(T2CC_ADDR_COUNT, 8'h1A);
    #1;
    `CHK({irq_match_second, irq_match_first, irq_overflow, wave_out_first}, 4'hD)
    i_t2cc_core_model.set_irq(1'h0, 3'h0);
    #1;
    `CHK({irq_match_second, irq_match_first}, 2'h0)
    i_t2cc_core_model.set_irq(1'h1, 3'h0);
    wr(T2CC_ADDR_FLAGS, 8'h02);
    rd(8'h17, 8'h04, 1'h1);
    i_t2cc_core_model.set_irq(1'h1, 3'h4);
    rd(T2CC_ADDR_FLAGS, 8'h00);
    wr(T2CC_ADDR_COUNT, 8'h12);
    run(3'h1, 6);
    rd(T2CC_ADDR_FLAGS, 8'h04);
    #1;
    `CHK(wave_out_first, 1'h1)
    wr(T2CC_ADDR_FLAGS, 8'h07);
    wr(T2CC_ADDR_COUNT, 8'hF8);
    run(3'h1, 12);
    rd(T2CC_ADDR_COUNT, 8'h04);
    rd(T2CC_ADDR_FLAGS, 8'h01);
    #1;
    `CHK(irq_overflow, 1'h1)
    wr(T2CC_ADDR_ENABLES, 8'h00);
    @(posedge mclk);
    #1;
    `CHK(irq_overflow, 1'h0)
    // phase-correct with top from compare first: 1,2,3,2,1,0 then reverse at zero
    wr(T2CC_ADDR_FLAGS, 8'h07);
    i_t2cc_core_model.set_mode(2'h1);
    wr(T2CC_ADDR_CMP_FIRST, 8'h03);
    wr(T2CC_ADDR_COUNT, 8'h01);
    wr(T2CC_ADDR_CTRL_B, 8'h09);
    repeat (4) @(posedge mclk);
    wr(T2CC_ADDR_CTRL_B, 8'h08);
    rd(T2CC_ADDR_FLAGS, 8'h03);
    rd(T2CC_ADDR_COUNT, 8'h01);
    i_t2cc_core_model.set_mode(2'h0);
    $display("test match_and_irq done");
    repeat (4) @(posedge mclk);
    print_verdict;
  end
endmodule

bind t2cc_timer t2cc_timer_monitor i_t2cc_timer_monitor (.mclk(mclk), .rst_n(rst_n),
  .core_addr(core_addr), .core_io_space(core_io_space), .core_wr(core_wr),
  .core_rd(core_rd), .core_wdata(core_wdata), .core_rdata(core_rdata),
  .global_irq_enable(global_irq_enable), .irq_overflow(irq_overflow),
  .irq_match_first(irq_match_first), .irq_match_second(irq_match_second));
